// >>> core/acm_params.svh
/*
  constants of the audio clock monitor registers: offsets, field positions,
  reset values, rate codes and timing counts.
  assumes: included by its bare name from the package and the design files.
*/
`ifndef ACM_PARAMS_SVH
`define ACM_PARAMS_SVH

// register offsets
`define ACM_OFS_RATE_MON 8'h37
`define ACM_OFS_RATIO_LOW 8'h38
`define ACM_OFS_DETECT 8'h39
`define ACM_OFS_PGM_SEL 8'h40

// reset values
`define ACM_RST_RATE_MON 8'h00
`define ACM_RST_RATIO_LOW 8'h00
`define ACM_RST_DETECT 8'h00
`define ACM_RST_PGM_SEL 8'h01

// field positions
`define ACM_BIT_RATE_ERR 0
`define ACM_BIT_BCLK_VALID 1
`define ACM_BIT_BCLK_MISSING 2
`define ACM_BIT_PLL_LOCK 3
`define ACM_BIT_PLL_OVER 4
`define ACM_BIT_BCLK_RANGE 5
`define ACM_BIT_FORCE_LEFT 3
`define ACM_BIT_FORCE_RIGHT 2

// detected rate codes
`define ACM_CODE_ERROR 4'h0
`define ACM_CODE_16K 4'h4
`define ACM_CODE_32K 4'h6
`define ACM_CODE_48K 4'h9
`define ACM_CODE_96K 4'hb
`define ACM_CODE_192K 4'hd

// bit clock ratio limits, in bit clocks per frame
`define ACM_RATIO_MIN 10'h020
`define ACM_RATIO_MAX 10'h200
`define ACM_RATIO_SAT 10'h3ff

// timing: system clock period and frame period boundaries in ns
`define ACM_CLK_NS 20
`define ACM_BOUND_192_NS 7800
`define ACM_BOUND_96_NS 15600
`define ACM_BOUND_48_NS 26000
`define ACM_BOUND_32_NS 46800
`define ACM_BOUND_16_NS 93700
`define ACM_MISSING_NS 200000
`define ACM_BOUND_192_CYC (`ACM_BOUND_192_NS / `ACM_CLK_NS)
`define ACM_BOUND_96_CYC (`ACM_BOUND_96_NS / `ACM_CLK_NS)
`define ACM_BOUND_48_CYC (`ACM_BOUND_48_NS / `ACM_CLK_NS)
`define ACM_BOUND_32_CYC (`ACM_BOUND_32_NS / `ACM_CLK_NS)
`define ACM_BOUND_16_CYC (`ACM_BOUND_16_NS / `ACM_CLK_NS)
`define ACM_MISSING_CYC (`ACM_MISSING_NS / `ACM_CLK_NS)

`endif

// >>> core/acm_pkg.sv
/*
  types of the audio clock monitor registers.
  assumes: acm_params.svh on the include path.
*/
package acm_pkg;
  `include "acm_params.svh"

  typedef logic [3:0] acm_rate_t;
  typedef logic [9:0] acm_ratio_t;
  typedef logic [13:0] acm_period_t;

  // processing program choices
  typedef enum logic [1:0]
  {
    ACM_PGM_RAM,
    ACM_PGM_ROM1,
    ACM_PGM_ROM2,
    ACM_PGM_ROM3
  } acm_pgm_e;
endpackage

// >>> core/acm_frame_if.sv
/*
  carries the per-frame bit clock count from the bit clock domain to the
  system clock domain.
  assumes: ratio is held stable for a whole frame after each toggle.
*/
`timescale 1ns/1ps
interface acm_frame_if;
  import acm_pkg::*;
  acm_ratio_t ratio; // bit clocks counted in the last frame
  logic frame_toggle; // flips once per frame
  modport counter (output ratio, output frame_toggle);
  modport monitor (input ratio, input frame_toggle);
endinterface

// >>> core/acm_bclk_counter.sv
/*
  counts bit clock cycles per audio frame on the bit clock itself.
  assumes: frame clock changes on the bit clock; the bit clock may stop.
*/
`timescale 1ns/1ps
`include "acm_params.svh"
module acm_bclk_counter
  import acm_pkg::*;
(
  input wire logic bit_clock_pin_in, // bit clock, clocks this module
  input wire logic arst_n_in, // asynchronous reset, active low
  input wire logic frame_clock_in, // frame clock pin
  acm_frame_if.counter frame_if // count and frame event out
);
  logic frame_s1;
  logic frame_s2;
  logic frame_s3;
  acm_ratio_t count;
  acm_ratio_t held;
  logic toggle;
  wire frame_start = frame_s2 & ~frame_s3;
  wire count_full = (count == `ACM_RATIO_SAT);

  // frame clock passes two flops before use
  always_ff @(posedge bit_clock_pin_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      frame_s3 <= 1'b0;
    end
    else
    begin
      frame_s1 <= frame_clock_in;
      frame_s2 <= frame_s1;
      frame_s3 <= frame_s2;
    end
  end

  // count bit clocks between frame starts, saturating
  always_ff @(posedge bit_clock_pin_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      count <= 10'h000;
      held <= 10'h000;
      toggle <= 1'b0;
    end
    else if (frame_start)
    begin
      held <= count;
      count <= 10'h001;
      toggle <= ~toggle;
    end
    else if (!count_full)
    begin
      count <= count + 10'h001;
    end
  end

  assign frame_if.ratio = held;
  assign frame_if.frame_toggle = toggle;
endmodule

// >>> core/acm_clock_monitor_regs.sv
/*
  clock monitor and program select registers of the audio amplifier.
  holds the sample rate monitor, bit clock ratio, clock detect flags and the
  program select / forced high impedance register, plus the frame timing
  measurement that feeds them.
  assumes: register port driven by the control interface logic on clk_in;
  bit clock and frame clock come from the audio source; pll flags come from
  an analog block, asynchronous to clk_in.
*/
`timescale 1ns/1ps
`include "acm_params.svh"
module acm_clock_monitor_regs
  import acm_pkg::*;
#(
  parameter int MISSING_CYC = `ACM_MISSING_CYC // frames absent this long: missing
)
(
  input wire logic clk_in, // system clock, 50 MHz
  input wire logic arst_n_in, // asynchronous reset, active low
  input wire logic bit_clock_pin_in, // bit clock from audio source
  input wire logic frame_clock_in, // frame clock from audio source
  input wire logic [7:0] reg_addr_in, // register address
  input wire logic reg_wr_in, // write strobe, one cycle
  input wire logic reg_rd_in, // read strobe, one cycle
  input wire logic [7:0] reg_wdata_in, // write data
  input wire acm_rate_t configured_rate_in, // 0: auto detect, else fixed code
  input wire logic ignore_rate_error_in, // do not mute on rate error
  input wire logic pll_enable_in, // pll enabled
  input wire logic pll_lock_in, // pll lock, asynchronous
  input wire logic pll_over_rate_in, // pll over rate, asynchronous
  input wire logic parallel_bridge_mono_in, // outputs in bridge mono mode
  input wire logic state_left_high_z_in, // left hi-z from state control
  input wire logic state_right_high_z_in, // right hi-z from state control
  output logic [7:0] reg_rdata_out, // read data, valid cycle after strobe
  output logic reg_rvalid_out, // read data valid, one cycle
  output logic left_high_z_out, // left channel to high impedance
  output logic right_high_z_out, // right channel to high impedance
  output acm_pgm_e program_select_out, // processing program
  output logic rate_error_mute_out // rate error acted on by audio path
);
  acm_frame_if frame_if ();

  // bit clock domain counter
  acm_bclk_counter u_counter
  (
    .bit_clock_pin_in (bit_clock_pin_in),
    .arst_n_in (arst_n_in),
    .frame_clock_in (frame_clock_in),
    .frame_if (frame_if.counter)
  );

  // synchronisers for the frame event and the pll flags
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic lock_s1;
  logic lock_s2;
  logic over_s1;
  logic over_s2;

  // measured values
  acm_period_t period_count;
  acm_period_t last_period;
  acm_ratio_t ratio;
  acm_ratio_t prev_ratio;
  logic ratio_seen;
  logic [1:0] frames_seen;
  logic missing;
  acm_rate_t rate_code;

  // register contents
  logic [1:0] rate_mon_spare;
  logic [1:0] detect_spare;
  logic [3:0] pgm_spare;
  logic force_left;
  logic force_right;
  acm_pgm_e pgm_sel;
  logic [5:0] detect_flags;
  logic [7:0] next_rdata;

  // frame event and period classification
  wire frame_event = tog_s2 ^ tog_s3;
  wire period_full = (period_count == 14'h3fff);
  wire timeout = (32'(period_count) >= MISSING_CYC);

  // classify the frame period in system clocks into a rate code
  function automatic acm_rate_t classify(input acm_period_t cyc);
    acm_rate_t code;
    code = `ACM_CODE_ERROR;
    if (32'(cyc) < `ACM_BOUND_192_CYC / 2)
      code = `ACM_CODE_ERROR;
    else if (32'(cyc) < `ACM_BOUND_192_CYC)
      code = `ACM_CODE_192K;
    else if (32'(cyc) < `ACM_BOUND_96_CYC)
      code = `ACM_CODE_96K;
    else if (32'(cyc) < `ACM_BOUND_48_CYC)
      code = `ACM_CODE_48K;
    else if (32'(cyc) < `ACM_BOUND_32_CYC)
      code = `ACM_CODE_32K;
    else if (32'(cyc) < `ACM_BOUND_16_CYC)
      code = `ACM_CODE_16K;
    return code;
  endfunction

  // bit clock ratio checks
  wire ratio_in_range = (ratio >= `ACM_RATIO_MIN) && (ratio <= `ACM_RATIO_MAX);
  wire ratio_stable = ratio_seen && (ratio == prev_ratio);
  wire rate_auto = (configured_rate_in == `ACM_CODE_ERROR);

  // rate error: invalid rate in auto mode, mismatch in fixed mode
  wire rate_error = rate_auto ? (rate_code == `ACM_CODE_ERROR)
                              : (configured_rate_in != rate_code);

  // flag vector assembled from live measurements
  wire [5:0] live_flags =
  {
    missing | ~ratio_in_range,
    over_s2,
    pll_enable_in & lock_s2,
    missing,
    ~missing & ratio_stable & ratio_in_range,
    rate_error
  };

  // address decode
  wire sel_rate_mon = (reg_addr_in == `ACM_OFS_RATE_MON);
  wire sel_ratio_low = (reg_addr_in == `ACM_OFS_RATIO_LOW);
  wire sel_detect = (reg_addr_in == `ACM_OFS_DETECT);
  wire sel_pgm = (reg_addr_in == `ACM_OFS_PGM_SEL);
  wire wr_rate_mon = reg_wr_in & sel_rate_mon;
  wire wr_detect = reg_wr_in & sel_detect;
  wire wr_pgm = reg_wr_in & sel_pgm;

  // output enables: force only acts outside bridge mono mode
  wire force_active_left = force_left & ~parallel_bridge_mono_in;
  wire force_active_right = force_right & ~parallel_bridge_mono_in;
  wire next_left_high_z = force_active_left | state_left_high_z_in;
  wire next_right_high_z = force_active_right | state_right_high_z_in;

  // read data selection; unmapped addresses read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (sel_rate_mon)
      next_rdata = {rate_mon_spare, ratio[9:8], rate_code};
    else if (sel_ratio_low)
      next_rdata = ratio[7:0];
    else if (sel_detect)
      next_rdata = {detect_spare, detect_flags};
    else if (sel_pgm)
      next_rdata = {pgm_spare, force_left, force_right, pgm_sel};
  end

  // frame toggle from the bit clock domain, two flops then edge detect
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end
    else
    begin
      tog_s1 <= frame_if.frame_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // pll flags from the analog block
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      over_s1 <= 1'b0;
      over_s2 <= 1'b0;
    end
    else
    begin
      lock_s1 <= pll_lock_in;
      lock_s2 <= lock_s1;
      over_s1 <= pll_over_rate_in;
      over_s2 <= over_s1;
    end
  end

  // frame period counter in system clocks
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      period_count <= 14'h0000;
    else if (frame_event)
      period_count <= 14'h0001;
    else if (!period_full)
      period_count <= period_count + 14'h0001;
  end

  // capture ratio and period on each frame; ratio held stable by the counter
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ratio <= 10'h000;
      prev_ratio <= 10'h000;
      last_period <= 14'h0000;
      frames_seen <= 2'b00;
    end
    else if (frame_event)
    begin
      prev_ratio <= ratio;
      ratio <= frame_if.ratio;
      last_period <= period_count;
      if (frames_seen != 2'b11)
        frames_seen <= frames_seen + 2'b01;
    end
    else if (missing)
    begin
      frames_seen <= 2'b00;
    end
  end

  // the first period after start or loss is partial and not trusted
  assign ratio_seen = (frames_seen == 2'b11);

  // missing bit clock: no frame for the timeout interval
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      missing <= 1'b0;
    else if (frame_event)
      missing <= 1'b0;
    else if (timeout)
      missing <= 1'b1;
  end

  // detected rate code follows the latest trusted period
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rate_code <= `ACM_CODE_ERROR;
    else if (missing || !ratio_seen)
      rate_code <= `ACM_CODE_ERROR;
    else
      rate_code <= classify(last_period);
  end

  // flags track live state; reading never clears them
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      detect_flags <= 6'h00;
    else
      detect_flags <= live_flags;
  end

  // writable register fields
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rate_mon_spare <= 2'(`ACM_RST_RATE_MON >> 6);
      detect_spare <= 2'(`ACM_RST_DETECT >> 6);
      pgm_spare <= 4'(`ACM_RST_PGM_SEL >> 4);
      force_left <= 1'(`ACM_RST_PGM_SEL >> `ACM_BIT_FORCE_LEFT);
      force_right <= 1'(`ACM_RST_PGM_SEL >> `ACM_BIT_FORCE_RIGHT);
      pgm_sel <= acm_pgm_e'(2'(`ACM_RST_PGM_SEL));
    end
    else
    begin
      if (wr_rate_mon)
        rate_mon_spare <= reg_wdata_in[7:6];
      if (wr_detect)
        detect_spare <= reg_wdata_in[7:6];
      if (wr_pgm)
      begin
        pgm_spare <= reg_wdata_in[7:4];
        force_left <= reg_wdata_in[`ACM_BIT_FORCE_LEFT];
        force_right <= reg_wdata_in[`ACM_BIT_FORCE_RIGHT];
        pgm_sel <= acm_pgm_e'(reg_wdata_in[1:0]);
      end
    end
  end

  // read port answers the cycle after the strobe
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= next_rdata;
    end
  end

  // registered outputs to the power stage and processor
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      left_high_z_out <= 1'b0;
      right_high_z_out <= 1'b0;
      program_select_out <= acm_pgm_e'(2'(`ACM_RST_PGM_SEL));
      rate_error_mute_out <= 1'b0;
    end
    else
    begin
      left_high_z_out <= next_left_high_z;
      right_high_z_out <= next_right_high_z;
      program_select_out <= pgm_sel;
      rate_error_mute_out <= rate_error & ~ignore_rate_error_in;
    end
  end
endmodule

// >>> test/acm_audio_source.sv
/*
  model of the audio source: makes the bit clock and the frame clock.
  assumes: bit clock period 15 ns, phase unrelated to the system clock.
*/
`timescale 1ns/1ps
module acm_audio_source
(
  input wire logic run_in, // bit clock runs while high
  input wire logic [9:0] ratio_in, // bit clocks per frame
  output logic bit_clock_out, // bit clock
  output logic frame_clock_out // frame clock, rises at frame start
);
  int cnt;

  // bit clock stands low while stopped, odd start keeps edges off clk_in
  initial
  begin
    bit_clock_out = 1'b0;
    frame_clock_out = 1'b0;
    cnt = 0;
    #3.1;
    forever
    begin
      #7.5;
      bit_clock_out = run_in ? ~bit_clock_out : 1'b0;
    end
  end

  // frame clock changes on the falling bit clock, high for half a frame
  always @(negedge bit_clock_out)
  begin
    cnt = (cnt + 1 >= int'(ratio_in)) ? 0 : cnt + 1;
    frame_clock_out = (cnt < int'(ratio_in) / 2);
  end
endmodule

// >>> test/acm_clock_monitor_regs_properties.sv
/*
  checker of the clock monitor registers, bound to the top module.
  assumes: sees only top ports; reset is asynchronous, active low.
*/
`timescale 1ns/1ps
module acm_clock_monitor_regs_properties
  import acm_pkg::*;
#(
  parameter int MISSING_CYC = 10000 // missing limit, handed on by the bind
)
(
  input wire logic clk_in, // system clock
  input wire logic arst_n_in, // reset, active low
  input wire logic [7:0] reg_addr_in, // register address
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  input wire logic [7:0] reg_wdata_in, // write data
  input wire logic pll_enable_in, // pll enabled
  input wire logic parallel_bridge_mono_in, // bridge mono mode
  input wire logic state_left_high_z_in, // left hi-z from state control
  input wire logic state_right_high_z_in, // right hi-z from state control
  input wire logic [7:0] reg_rdata_out, // read data
  input wire logic reg_rvalid_out, // read data valid
  input wire logic left_high_z_out, // left hi-z
  input wire logic right_high_z_out, // right hi-z
  input wire acm_pgm_e program_select_out // program choice
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // steps of a program register write and of a pll-off status read
  sequence s_pgm_write;
    reg_wr_in && reg_addr_in == 8'h40;
  endsequence
  sequence s_pll_off_read;
    (!pll_enable_in)[*3] ##0 (reg_rd_in && reg_addr_in == 8'h39);
  endsequence

  chk_rvalid_pulse: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read strobe without valid");
  chk_rvalid_idle: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("valid without read strobe");
  chk_unmapped_zero: assert property (reg_rd_in &&
    !(reg_addr_in inside {8'h37, 8'h38, 8'h39, 8'h40}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_pgm_follow: assert property (s_pgm_write |-> ##2
    program_select_out == $past(reg_wdata_in[1:0], 2)) else $error("program not taken");
  chk_pgm_readback: assert property (s_pgm_write ##1 (!reg_wr_in)[*2] ##1
    (reg_rd_in && reg_addr_in == 8'h40) |=> reg_rdata_out == $past(reg_wdata_in, 4))
    else $error("program register readback wrong");
  chk_force_left: assert property (s_pgm_write ##0 reg_wdata_in[3]
    ##1 !parallel_bridge_mono_in |=> left_high_z_out) else $error("left not forced");
  chk_force_right: assert property (s_pgm_write ##0 reg_wdata_in[2]
    ##1 !parallel_bridge_mono_in |=> right_high_z_out) else $error("right not forced");
  chk_state_left: assert property (state_left_high_z_in |=> left_high_z_out)
    else $error("state hi-z not passed");
  chk_force_hold: assert property (left_high_z_out && !$past(state_left_high_z_in) &&
    !$past(reg_wr_in) && !parallel_bridge_mono_in |=> left_high_z_out)
    else $error("forced left released");
  chk_mono_blocks: assert property (parallel_bridge_mono_in && !state_left_high_z_in &&
    !state_right_high_z_in |=> !left_high_z_out && !right_high_z_out)
    else $error("force acted in mono");
  chk_pll_off: assert property (s_pll_off_read |=> !reg_rdata_out[3])
    else $error("lock shown while pll off");
endmodule

bind acm_clock_monitor_regs acm_clock_monitor_regs_properties
  #(.MISSING_CYC(MISSING_CYC)) acm_clock_monitor_regs_properties_inst (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .pll_enable_in(pll_enable_in), .parallel_bridge_mono_in(parallel_bridge_mono_in),
  .state_left_high_z_in(state_left_high_z_in), .state_right_high_z_in(state_right_high_z_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .left_high_z_out(left_high_z_out), .right_high_z_out(right_high_z_out),
  .program_select_out(program_select_out));

// >>> test/acm_clock_monitor_regs_tb_top.sv
/*
  testbench of the clock monitor registers with an audio source model.
  assumes: 50 MHz clk_in, 15 ns bit clock, short missing limit.
*/
`timescale 1ns/1ps
module acm_clock_monitor_regs_tb_top;
  import acm_pkg::*;
  localparam int MISS = 2000;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic run = 1'b0;
  logic [9:0] ratio = 10'h12c;
  logic bclk, fclk, wr = 1'b0, rd = 1'b0, rvalid, hz_l, hz_r, mute;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  acm_rate_t cfg = 4'h0;
  logic ign = 1'b0, pll_en = 1'b0, lock = 1'b0, over = 1'b0, mono = 1'b0;
  logic st_l = 1'b0, st_r = 1'b0;
  acm_pgm_e pgm;
  int fails = 0;
  int n_tests = 0;

  always #10 clk_in = ~clk_in;

  acm_audio_source acm_audio_source_inst (.run_in(run), .ratio_in(ratio),
    .bit_clock_out(bclk), .frame_clock_out(fclk));

  acm_clock_monitor_regs #(.MISSING_CYC(MISS)) acm_clock_monitor_regs_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .bit_clock_pin_in(bclk),
    .frame_clock_in(fclk), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .configured_rate_in(cfg), .ignore_rate_error_in(ign),
    .pll_enable_in(pll_en), .pll_lock_in(lock), .pll_over_rate_in(over),
    .parallel_bridge_mono_in(mono), .state_left_high_z_in(st_l),
    .state_right_high_z_in(st_r), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .left_high_z_out(hz_l), .right_high_z_out(hz_r), .program_select_out(pgm),
    .rate_error_mute_out(mute));

  // shared compare, wait and register access
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    check({7'h00, rvalid}, 8'h01, "read valid");
    check(rdata & m, e, "register read");
  endtask

  // scenarios
  task automatic t_reset();
    expect_reg(8'h37, 8'hff, 8'h00);
    expect_reg(8'h38, 8'hff, 8'h00);
    expect_reg(8'h39, 8'hca, 8'h00);
    expect_reg(8'h40, 8'hff, 8'h01);
    expect_reg(8'h41, 8'hff, 8'h00);
    check({6'h00, pgm}, 8'h01, "program after reset");
    reg_write(8'h38, 8'hff);
    expect_reg(8'h38, 8'hff, 8'h00);
    reg_write(8'h37, 8'hff);
    expect_reg(8'h37, 8'hff, 8'hc0);
    reg_write(8'h37, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_program();
    for (int k = 0; k < 4; k++)
    begin
      reg_write(8'h40, 8'h50 | 8'(k));
      cyc(1);
      check({6'h00, pgm}, 8'(k), "program select");
      expect_reg(8'h40, 8'hff, 8'h50 | 8'(k));
    end
    reg_write(8'h40, 8'h0b);
    cyc(1);
    check({6'h00, hz_l, hz_r}, 8'h02, "force left");
    reg_write(8'h40, 8'h07);
    cyc(1);
    check({6'h00, hz_l, hz_r}, 8'h01, "force right");
    st_r = 1'b1;
    cyc(1);
    st_r = 1'b0;
    reg_write(8'h37, 8'h00);
    cyc(2);
    check({6'h00, hz_l, hz_r}, 8'h01, "force held");
    st_l = 1'b1;
    cyc(1);
    check({6'h00, hz_l, hz_r}, 8'h03, "state control");
    st_l = 1'b0;
    mono = 1'b1;
    reg_write(8'h40, 8'h0d);
    cyc(1);
    check({6'h00, hz_l, hz_r}, 8'h00, "mono ignores force");
    mono = 1'b0;
    cyc(1);
    check({6'h00, hz_l, hz_r}, 8'h03, "force after mono");
    reg_write(8'h40, 8'h01);
    $display("test program done");
  endtask
  task automatic t_rate(input logic [9:0] r, input logic [7:0] mon, input logic [7:0] st);
    ratio = r;
    run = 1'b1;
    cyc(3000);
    expect_reg(8'h37, 8'hff, mon);
    expect_reg(8'h38, 8'hff, r[7:0]);
    expect_reg(8'h39, 8'h27, st);
    expect_reg(8'h39, 8'h27, st);
    $display("test rate done");
  endtask
  task automatic t_pll();
    pll_en = 1'b1;
    lock = 1'b1;
    cyc(5);
    expect_reg(8'h39, 8'h18, 8'h08);
    over = 1'b1;
    cyc(5);
    expect_reg(8'h39, 8'h18, 8'h18);
    pll_en = 1'b0;
    cyc(5);
    expect_reg(8'h39, 8'h18, 8'h10);
    over = 1'b0;
    lock = 1'b0;
    $display("test pll done");
  endtask
  task automatic t_fixed();
    cfg = 4'h9;
    cyc(5);
    expect_reg(8'h39, 8'h01, 8'h01);
    check({7'h00, mute}, 8'h01, "mute on error");
    ign = 1'b1;
    cyc(5);
    expect_reg(8'h39, 8'h01, 8'h01);
    check({7'h00, mute}, 8'h00, "mute ignored");
    cfg = 4'hd;
    cyc(5);
    expect_reg(8'h39, 8'h01, 8'h00);
    cfg = 4'h0;
    ign = 1'b0;
    $display("test fixed done");
  endtask
  task automatic t_missing();
    run = 1'b0;
    cyc(MISS + 600);
    expect_reg(8'h39, 8'h27, 8'h25);
    expect_reg(8'h37, 8'h0f, 8'h00);
    $display("test missing done");
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog, well beyond the some 8700 cycles the tests take
  initial
  begin
    #400000;
    $display("[ERR] %0t watchdog expired", $time);
    fails++;
    conclude();
  end

  // reset for three cycles, then the scenarios
  initial
  begin
    repeat (3) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    t_reset();
    t_program();
    t_rate(10'h12c, 8'h1d, 8'h02);
    t_pll();
    t_fixed();
    t_rate(10'h258, 8'h2b, 8'h20);
    t_missing();
    conclude();
  end
endmodule
